//--- hw/sfr_router.sv
/*
 Sequence input/output function router. Ten digital input channels are
 mapped onto input functions, which steer the drive core; sixteen output
 functions from the core are mapped onto six digital output channels.
 Assumes one 250 MHz clock, a classic Wishbone slave port, pins that are
 asynchronous, and core-side signals on the same clock.
*/
// Our own choices: the Wishbone register port and the address map.
// Overview of operation
// - Twenty-five input functions, any to ten channels.
// - Sixteen output functions, freely mapped to outputs.
// - Outputs numbered one to six, inputs one-ten.
// - Servo-on powers motor; off removes power.
// - Alarm reset clears active servo alarm.
// - Gain switch selects second gain group.
// - Forward torque limit clamps to forward setting.
// - Reverse torque limit clamps to reverse setting.
// - Forward overtravel blocks forward rotation.
// - Reverse overtravel blocks reverse rotation.
// - Proportional-only input disables integral action.
// - Mode switch honoured only in combined modes.
// - Preset mode: speed selects, analog, direction.
// - Speed mode zero clamp ignores small commands.
// - Pulse inhibit discards position pulses.
// - Absolute data transmit drives encoder outputs.
// - Position clear resets command, feedback, error.
// - Start input runs or stops speed modes.
// - Gear switch selects second gear pair.
// - Multi-turn reset clears rotation count.
`timescale 1ns/1ns
`default_nettype none

module sfr_router (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [9:0] in_ch_i,
	input wire logic pulse_cmd_i,
	output logic [5:0] out_ch_o,
	input wire logic [15:0] out_func_i,
	input wire logic signed [15:0] analog_speed_i,
	input wire logic enc_a_i,
	input wire logic enc_b_i,
	input wire logic abs_a_i,
	input wire logic abs_b_i,
	output logic encoder_pulse_out_a_o,
	output logic encoder_pulse_out_b_o,
	output logic motor_power_o,
	output logic alarm_clear_o,
	output logic gain_group2_o,
	output logic [15:0] fwd_torque_clamp_o,
	output logic [15:0] rev_torque_clamp_o,
	output logic fwd_run_allow_o,
	output logic rev_run_allow_o,
	output logic p_only_o,
	output logic [2:0] active_mode_o,
	output logic signed [15:0] speed_cmd_o,
	output logic pulse_cmd_o,
	output logic pos_clear_o,
	output logic run_o,
	output logic [15:0] gear_num_o,
	output logic [15:0] gear_den_o,
	output logic multiturn_clear_o
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
			input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = wdat[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Channel numbers start at one; zero and out-of-range mean unassigned.
	function automatic logic pick_input(input logic [9:0] pins,
			input logic [3:0] sel);
		logic r;
		r = 1'b0;
		for (int c = 1; c <= sfr_pkg::NUM_IN_CH; c++) begin
			if (sel == 4'(c)) begin
				r = pins[c-1];
			end
		end
		return r;
	endfunction

	function automatic logic pick_output(input logic [15:0] fns,
			input logic [4:0] sel);
		logic r;
		r = 1'b0;
		for (int f = 1; f <= sfr_pkg::NUM_OUT_FN; f++) begin
			if (sel == 5'(f)) begin
				r = fns[f-1];
			end
		end
		return r;
	endfunction

	// A combined mode resolves to one of its two constituent modes.
	function automatic logic [2:0] resolve_mode(input logic [2:0] cfg,
			input logic sw);
		logic [2:0] r;
		r = cfg;
		if (cfg == sfr_pkg::MODE_POS_SPEED) begin
			r = sw ? sfr_pkg::MODE_SPEED : sfr_pkg::MODE_POS;
		end else if (cfg == sfr_pkg::MODE_SPEED_TORQUE) begin
			r = sw ? sfr_pkg::MODE_TORQUE : sfr_pkg::MODE_SPEED;
		end else if (cfg == sfr_pkg::MODE_POS_TORQUE) begin
			r = sw ? sfr_pkg::MODE_TORQUE : sfr_pkg::MODE_POS;
		end
		return r;
	endfunction

	function automatic logic [15:0] magnitude(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	logic [10:0] pins_sync;
	logic [9:0] in_pins;
	logic pulse_pin;

	sfr_sync #(
		.WIDTH(11)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({pulse_cmd_i, in_ch_i}),
		.sync_o(pins_sync)
	);

	assign in_pins = pins_sync[9:0];
	assign pulse_pin = pins_sync[10];

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	logic ack_q;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic [2:0] mode_q;
	logic [31:0] imap_q [0:3];
	logic [29:0] omap_q;
	logic [31:0] tlim_q;
	logic [15:0] zclamp_q;
	logic [31:0] gear_basic_q;
	logic [31:0] gear_second_q;
	logic [15:0] preset_q [0:2];
	logic [24:0] fn;
	logic [5:0] out_d;
	logic [5:0] out_q;
	logic wr;
	logic [31:0] ctrl_word;
	logic [31:0] wmerge;

	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	assign ctrl_word = {29'h0, mode_q};
	assign wmerge = merge_bytes(rdat_d, wb_dat_i, wb_sel_i);

	always_comb begin
		unique case (wb_adr_i)
			sfr_pkg::OFS_CTRL: rdat_d = ctrl_word;
			sfr_pkg::OFS_IN_MAP0: rdat_d = imap_q[0];
			sfr_pkg::OFS_IN_MAP1: rdat_d = imap_q[1];
			sfr_pkg::OFS_IN_MAP2: rdat_d = imap_q[2];
			sfr_pkg::OFS_IN_MAP3: rdat_d = imap_q[3];
			sfr_pkg::OFS_OUT_MAP: rdat_d = {2'h0, omap_q};
			sfr_pkg::OFS_TORQUE_LIM: rdat_d = tlim_q;
			sfr_pkg::OFS_ZCLAMP: rdat_d = {16'h0, zclamp_q};
			sfr_pkg::OFS_GEAR_BASIC: rdat_d = gear_basic_q;
			sfr_pkg::OFS_GEAR_SECOND: rdat_d = gear_second_q;
			sfr_pkg::OFS_PRESET0: rdat_d = {16'h0, preset_q[0]};
			sfr_pkg::OFS_PRESET1: rdat_d = {16'h0, preset_q[1]};
			sfr_pkg::OFS_PRESET2: rdat_d = {16'h0, preset_q[2]};
			sfr_pkg::OFS_FUNC_STAT: rdat_d = {7'h0, fn};
			sfr_pkg::OFS_PIN_STAT: rdat_d = {10'h0, out_q, 6'h0, in_pins};
			default: rdat_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
			rdat_q <= rdat_d;
		end
	end

	// Writes land on the edge at which the master samples ack high, so a
	// write never takes effect ahead of its own acknowledge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= sfr_pkg::CTRL_MODE_RST;
			for (int i = 0; i < 4; i++) begin
				imap_q[i] <= sfr_pkg::MAP_RST;
			end
			omap_q <= sfr_pkg::MAP_RST[29:0];
			tlim_q <= {sfr_pkg::TORQUE_LIM_RST, sfr_pkg::TORQUE_LIM_RST};
			zclamp_q <= sfr_pkg::ZCLAMP_RST;
			gear_basic_q <= {sfr_pkg::GEAR_RST, sfr_pkg::GEAR_RST};
			gear_second_q <= {sfr_pkg::GEAR_RST, sfr_pkg::GEAR_RST};
			for (int i = 0; i < 3; i++) begin
				preset_q[i] <= sfr_pkg::PRESET_RST;
			end
		end else if (wr) begin
			unique case (wb_adr_i)
				sfr_pkg::OFS_CTRL: mode_q <= wmerge[2:0];
				sfr_pkg::OFS_IN_MAP0: imap_q[0] <= wmerge;
				sfr_pkg::OFS_IN_MAP1: imap_q[1] <= wmerge;
				sfr_pkg::OFS_IN_MAP2: imap_q[2] <= wmerge;
				sfr_pkg::OFS_IN_MAP3: imap_q[3] <= wmerge;
				sfr_pkg::OFS_OUT_MAP: omap_q <= wmerge[29:0];
				sfr_pkg::OFS_TORQUE_LIM: tlim_q <= wmerge;
				sfr_pkg::OFS_ZCLAMP: zclamp_q <= wmerge[15:0];
				sfr_pkg::OFS_GEAR_BASIC: gear_basic_q <= wmerge;
				sfr_pkg::OFS_GEAR_SECOND: gear_second_q <= wmerge;
				sfr_pkg::OFS_PRESET0: preset_q[0] <= wmerge[15:0];
				sfr_pkg::OFS_PRESET1: preset_q[1] <= wmerge[15:0];
				sfr_pkg::OFS_PRESET2: preset_q[2] <= wmerge[15:0];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Input function mapping
	// ------------------------------------------------------------------
	for (genvar f = 0; f < sfr_pkg::NUM_IN_FN; f++) begin : g_in
		assign fn[f] = pick_input(in_pins,
			imap_q[f / 8][(f % 8) * 4 +: 4]);
	end

	// ------------------------------------------------------------------
	// Output function mapping
	// ------------------------------------------------------------------
	for (genvar c = 0; c < sfr_pkg::NUM_OUT_CH; c++) begin : g_out
		assign out_d[c] = pick_output(out_func_i,
			omap_q[c * 5 +: 5]);
	end

	// ------------------------------------------------------------------
	// Function effects
	// ------------------------------------------------------------------
	logic [2:0] mode_act;
	logic in_pos;
	logic in_speed;
	logic in_preset;
	logic in_index;
	logic abs_tx;
	logic signed [15:0] preset_spd;
	logic signed [15:0] speed_d;
	logic [2:0] edge_now;
	logic [2:0] edge_q;

	assign mode_act = resolve_mode(mode_q,
		fn[sfr_pkg::FN_MODE_SWITCH]);
	assign in_pos = mode_act == sfr_pkg::MODE_POS;
	assign in_speed = mode_act == sfr_pkg::MODE_SPEED;
	assign in_preset = mode_act == sfr_pkg::MODE_PRESET;
	assign in_index = mode_act == sfr_pkg::MODE_INDEX;
	assign abs_tx = fn[sfr_pkg::FN_ABS_TX] & (in_pos | in_index);

	// Speed select 11 hands the analog command through.
	always_comb begin
		unique case ({fn[sfr_pkg::FN_SPEED_SEL4], fn[sfr_pkg::FN_SPEED_SEL3]})
			2'b00: preset_spd = preset_q[0];
			2'b01: preset_spd = preset_q[1];
			2'b10: preset_spd = preset_q[2];
			2'b11: preset_spd = analog_speed_i;
		endcase
	end

	always_comb begin
		speed_d = analog_speed_i;
		if (in_preset) begin
			speed_d = fn[sfr_pkg::FN_SPEED_DIR] ? 16'(-preset_spd)
				: preset_spd;
		end else if (in_speed && fn[sfr_pkg::FN_ZERO_CLAMP]
				&& magnitude(analog_speed_i) < zclamp_q) begin
			speed_d = 16'sh0000;
		end
	end

	// One-shot clears fire on the rising edge of their function.
	assign edge_now = {fn[sfr_pkg::FN_MULTITURN_RESET],
		fn[sfr_pkg::FN_POS_CLEAR], fn[sfr_pkg::FN_ALARM_RESET]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			edge_q <= 3'h0;
			out_q <= 6'h00;
			motor_power_o <= 1'b0;
			alarm_clear_o <= 1'b0;
			gain_group2_o <= 1'b0;
			fwd_torque_clamp_o <= sfr_pkg::TORQUE_FREE;
			rev_torque_clamp_o <= sfr_pkg::TORQUE_FREE;
			fwd_run_allow_o <= 1'b0;
			rev_run_allow_o <= 1'b0;
			p_only_o <= 1'b0;
			active_mode_o <= sfr_pkg::CTRL_MODE_RST;
			speed_cmd_o <= 16'sh0000;
			pulse_cmd_o <= 1'b0;
			pos_clear_o <= 1'b0;
			run_o <= 1'b0;
			gear_num_o <= sfr_pkg::GEAR_RST;
			gear_den_o <= sfr_pkg::GEAR_RST;
			multiturn_clear_o <= 1'b0;
			encoder_pulse_out_a_o <= 1'b0;
			encoder_pulse_out_b_o <= 1'b0;
		end else begin
			edge_q <= edge_now;
			out_q <= out_d;
			motor_power_o <= fn[sfr_pkg::FN_SERVO_ON];
			alarm_clear_o <= edge_now[0] & ~edge_q[0];
			gain_group2_o <= fn[sfr_pkg::FN_GAIN_SWITCH];
			fwd_torque_clamp_o <= fn[sfr_pkg::FN_FWD_TORQUE_LIM]
				? tlim_q[15:0] : sfr_pkg::TORQUE_FREE;
			rev_torque_clamp_o <= fn[sfr_pkg::FN_REV_TORQUE_LIM]
				? tlim_q[31:16] : sfr_pkg::TORQUE_FREE;
			fwd_run_allow_o <= ~fn[sfr_pkg::FN_FWD_OVERTRAVEL];
			rev_run_allow_o <= ~fn[sfr_pkg::FN_REV_OVERTRAVEL];
			p_only_o <= fn[sfr_pkg::FN_P_ONLY]
				& (mode_act != sfr_pkg::MODE_TORQUE);
			active_mode_o <= mode_act;
			speed_cmd_o <= speed_d;
			pulse_cmd_o <= pulse_pin
				& ~(in_pos & fn[sfr_pkg::FN_PULSE_INHIBIT]);
			pos_clear_o <= edge_now[1] & ~edge_q[1]
				& (in_pos | in_index);
			run_o <= (in_speed | in_preset)
				? fn[sfr_pkg::FN_START] : 1'b1;
			gear_num_o <= (in_pos & fn[sfr_pkg::FN_GEAR_SWITCH])
				? gear_second_q[15:0] : gear_basic_q[15:0];
			gear_den_o <= (in_pos & fn[sfr_pkg::FN_GEAR_SWITCH])
				? gear_second_q[31:16] : gear_basic_q[31:16];
			multiturn_clear_o <= edge_now[2] & ~edge_q[2];
			encoder_pulse_out_a_o <= abs_tx ? abs_a_i : enc_a_i;
			encoder_pulse_out_b_o <= abs_tx ? abs_b_i : enc_b_i;
		end
	end

	assign out_ch_o = out_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

endmodule

`default_nettype wire

//--- hw/sfr_pkg.sv
/*
 Constants for the sequence input/output function router: register
 offsets, field layouts, reset values, function and mode codes.
 Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package sfr_pkg;

	// ------------------------------------------------------------------
	// Channel and function counts
	// ------------------------------------------------------------------
	localparam int NUM_IN_CH = 10;
	localparam int NUM_OUT_CH = 6;
	localparam int NUM_IN_FN = 25;
	localparam int NUM_OUT_FN = 16;
	localparam int IN_SEL_W = 4;
	localparam int OUT_SEL_W = 5;
	localparam int IN_SEL_PER_WORD = 8;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_IN_MAP0 = 8'h04;
	localparam logic [7:0] OFS_IN_MAP1 = 8'h08;
	localparam logic [7:0] OFS_IN_MAP2 = 8'h0c;
	localparam logic [7:0] OFS_IN_MAP3 = 8'h10;
	localparam logic [7:0] OFS_OUT_MAP = 8'h14;
	localparam logic [7:0] OFS_TORQUE_LIM = 8'h18;
	localparam logic [7:0] OFS_ZCLAMP = 8'h1c;
	localparam logic [7:0] OFS_GEAR_BASIC = 8'h20;
	localparam logic [7:0] OFS_GEAR_SECOND = 8'h24;
	localparam logic [7:0] OFS_PRESET0 = 8'h28;
	localparam logic [7:0] OFS_PRESET1 = 8'h2c;
	localparam logic [7:0] OFS_PRESET2 = 8'h30;
	localparam logic [7:0] OFS_FUNC_STAT = 8'h34;
	localparam logic [7:0] OFS_PIN_STAT = 8'h38;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int PIN_STAT_OUT_LSB = 16;
	localparam logic [2:0] CTRL_MODE_RST = 3'h0;
	localparam logic [31:0] MAP_RST = 32'h0000_0000;
	localparam logic [15:0] TORQUE_LIM_RST = 16'hffff;
	localparam logic [15:0] TORQUE_FREE = 16'hffff;
	localparam logic [15:0] ZCLAMP_RST = 16'h0000;
	localparam logic [15:0] GEAR_RST = 16'h0001;
	localparam logic [15:0] PRESET_RST = 16'h0000;

	// ------------------------------------------------------------------
	// Control modes
	// ------------------------------------------------------------------
	localparam logic [2:0] MODE_POS = 3'h0;
	localparam logic [2:0] MODE_SPEED = 3'h1;
	localparam logic [2:0] MODE_PRESET = 3'h2;
	localparam logic [2:0] MODE_TORQUE = 3'h3;
	localparam logic [2:0] MODE_INDEX = 3'h4;
	localparam logic [2:0] MODE_POS_SPEED = 3'h5;
	localparam logic [2:0] MODE_SPEED_TORQUE = 3'h6;
	localparam logic [2:0] MODE_POS_TORQUE = 3'h7;

	// ------------------------------------------------------------------
	// Input function codes
	// ------------------------------------------------------------------
	localparam int FN_SERVO_ON = 0;
	localparam int FN_ALARM_RESET = 1;
	localparam int FN_GAIN_SWITCH = 2;
	localparam int FN_FWD_TORQUE_LIM = 3;
	localparam int FN_REV_TORQUE_LIM = 4;
	localparam int FN_FWD_OVERTRAVEL = 5;
	localparam int FN_REV_OVERTRAVEL = 6;
	localparam int FN_P_ONLY = 7;
	localparam int FN_MODE_SWITCH = 8;
	localparam int FN_SPEED_SEL3 = 9;
	localparam int FN_SPEED_SEL4 = 10;
	localparam int FN_SPEED_DIR = 11;
	localparam int FN_ZERO_CLAMP = 12;
	localparam int FN_PULSE_INHIBIT = 13;
	localparam int FN_ABS_TX = 14;
	localparam int FN_POS_CLEAR = 15;
	localparam int FN_START = 16;
	localparam int FN_GEAR_SWITCH = 17;
	localparam int FN_MULTITURN_RESET = 18;

endpackage

//--- hw/sfr_sync.sv
/*
 Two-stage synchroniser for a bus of independent level signals.
 Assumes each bit changes slowly compared with the clock; bits are not
 guaranteed to land in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module sfr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

`default_nettype wire

//--- verif/sfr_router_assertions.sv
/*
 Concurrent checks on the router's bus handshake, clear pulses and
 resolved control mode.
 Assumes one clock and a synchronous active-high reset at the top ports.
*/
`timescale 1ns/1ns
`default_nettype none

module sfr_router_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic alarm_clear_o,
	input wire logic pos_clear_o,
	input wire logic multiturn_clear_o,
	input wire logic p_only_o,
	input wire logic [2:0] active_mode_o
);
	// ----------------------------------------------------------------
	// Handshake
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_next_cycle: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_cause: assert property (
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");

	// ----------------------------------------------------------------
	// Function effects
	// ----------------------------------------------------------------
	// Clears act once per assertion; a held input must not repeat them.
	a_alarm_clr_pulse: assert property (
		alarm_clear_o |=> !alarm_clear_o)
		else $error("alarm clear longer than one cycle");
	a_pos_clr_pulse: assert property (
		pos_clear_o |=> !pos_clear_o)
		else $error("position clear longer than one cycle");
	a_pos_clr_mode: assert property (
		pos_clear_o |-> active_mode_o == sfr_pkg::MODE_POS ||
		active_mode_o == sfr_pkg::MODE_INDEX)
		else $error("position clear outside position modes");
	a_turn_clr_pulse: assert property (
		multiturn_clear_o |=> !multiturn_clear_o)
		else $error("multiturn clear longer than one cycle");
	a_mode_resolved: assert property (
		active_mode_o <= sfr_pkg::MODE_INDEX)
		else $error("combined mode left unresolved");
	a_p_only_mode: assert property (
		p_only_o |-> active_mode_o != sfr_pkg::MODE_TORQUE)
		else $error("proportional-only in torque mode");
endmodule

bind sfr_router sfr_router_chk i_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .alarm_clear_o, .pos_clear_o,
	.multiturn_clear_o, .p_only_o, .active_mode_o);

`default_nettype wire

//--- verif/sfr_host_model.sv
/*
 Host controller model driving the ten discrete input channels.
 Assumes the bench sets the wanted levels just after a clock edge.
*/
`timescale 1ns/1ns
`default_nettype none

module sfr_host_model (
	input wire logic clk_i,
	input wire logic slow_i,
	input wire logic [9:0] level_i,
	output logic [9:0] in_ch_o
);
	logic [9:0] stage_q;

	// The slow path adds one cycle of skew, like a sluggish output stage.
	always_ff @(posedge clk_i) begin
		stage_q <= level_i;
		in_ch_o <= slow_i ? stage_q : level_i;
	end
endmodule

`default_nettype wire

//--- verif/sfr_router_tb_top.sv
/*
 Self-checking bench for the function router: registers, input function
 mapping and effects, output mapping and clear pulses.
 Assumes sfr_host_model drives the input channels.
*/
`timescale 1ns/1ns
`default_nettype none

module sfr_router_tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct {
		int fn;
		int ch;
		logic [2:0] mode;
		logic on;
	} sfr_row_t;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pulse_cmd_i, slow_q;
	logic enc_a_i, enc_b_i, abs_a_i, abs_b_i, wb_ack_o, p_only_o, run_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [9:0] in_ch_i, pins_q;
	logic [15:0] out_func_i, fwd_torque_clamp_o, rev_torque_clamp_o;
	logic [15:0] gear_num_o, gear_den_o;
	logic signed [15:0] analog_speed_i, speed_cmd_o;
	logic [5:0] out_ch_o;
	logic [2:0] active_mode_o;
	logic encoder_pulse_out_a_o, encoder_pulse_out_b_o, motor_power_o;
	logic alarm_clear_o, gain_group2_o, fwd_run_allow_o, rev_run_allow_o;
	logic pulse_cmd_o, pos_clear_o, multiturn_clear_o;
	int errors, num_checks, n;
	int pfn[3] = '{1, 15, 18};
	logic [2:0] mexp[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h1, 3'h0};
	logic [15:0] spd[4] = '{16'h0064, 16'h00c8, 16'h012c, 16'h0005};
	sfr_row_t rows[16] = '{
		'{0, 1, 3'h0, 1'b1},
		'{2, 2, 3'h0, 1'b1},
		'{3, 3, 3'h0, 1'b1},
		'{4, 4, 3'h0, 1'b1},
		'{5, 5, 3'h0, 1'b1},
		'{6, 6, 3'h0, 1'b1},
		'{7, 7, 3'h1, 1'b1},
		'{7, 8, 3'h3, 1'b0},
		'{8, 9, 3'h5, 1'b1},
		'{8, 10, 3'h0, 1'b0},
		'{11, 1, 3'h2, 1'b1},
		'{12, 2, 3'h1, 1'b1},
		'{13, 3, 3'h0, 1'b1},
		'{14, 4, 3'h4, 1'b1},
		'{16, 5, 3'h1, 1'b1},
		'{17, 6, 3'h0, 1'b1}
	};

	sfr_host_model i_host (.clk_i, .slow_i(slow_q), .level_i(pins_q),
		.in_ch_o(in_ch_i));
	sfr_router i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .in_ch_i,
		.pulse_cmd_i, .out_ch_o, .out_func_i, .analog_speed_i, .enc_a_i,
		.enc_b_i, .abs_a_i, .abs_b_i, .encoder_pulse_out_a_o,
		.encoder_pulse_out_b_o, .motor_power_o, .alarm_clear_o,
		.gain_group2_o, .fwd_torque_clamp_o, .rev_torque_clamp_o,
		.fwd_run_allow_o, .rev_run_allow_o, .p_only_o, .active_mode_o,
		.speed_cmd_o, .pulse_cmd_o, .pos_clear_o, .run_o, .gear_num_o,
		.gear_den_o, .multiturn_clear_o);

	always #2 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// One bit per function: high while its effect shows at the ports.
	function automatic logic probe(int fn);
		case (fn)
			0: return motor_power_o;
			1: return alarm_clear_o;
			2: return gain_group2_o;
			3: return fwd_torque_clamp_o === 16'h0100;
			4: return rev_torque_clamp_o === 16'h0200;
			5: return !fwd_run_allow_o;
			6: return !rev_run_allow_o;
			7: return p_only_o;
			8: return active_mode_o === 3'h1;
			11: return speed_cmd_o === 16'hff9c;
			12: return speed_cmd_o === 16'h0000;
			13: return !pulse_cmd_o;
			14: return encoder_pulse_out_a_o && encoder_pulse_out_b_o;
			15: return pos_clear_o;
			16: return run_o;
			17: return gear_num_o === 16'h0007 && gear_den_o === 16'h0005;
			default: return multiturn_clear_o;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hf);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1);
		chk(k, 2, "bus ack latency");
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic map_fn(input int fn, input int ch);
		wb(1'b1, sfr_pkg::OFS_IN_MAP0 + 8'(4 * (fn / 8)),
			32'(ch) << (4 * (fn % 8)));
	endtask

	// Sets the pins, then counts cycles in which the function shows.
	task automatic hold(input int fn, input logic [9:0] v);
		@(posedge clk_i);
		pins_q <= v;
		n = 0;
		repeat (10) begin
			@(posedge clk_i);
			n += (probe(fn) === 1'b0) ? 0 : 1;
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#100000;
		errors++;
		$display("mismatch at %0t: watchdog", $time);
		finish_test();
	end

	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, slow_q, enc_a_i, enc_b_i} = 6'h00;
		{abs_a_i, abs_b_i, pulse_cmd_i} = 3'h7;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		pins_q = 10'h000;
		out_func_i = 16'h0000;
		analog_speed_i = 16'sh0005;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(fwd_torque_clamp_o, 32'h0000ffff, "clamp reset");
		chk(gear_num_o, 32'h1, "gear reset");
		wb(1'b1, sfr_pkg::OFS_TORQUE_LIM, 32'h0000_0100, 4'h3);
		wb(1'b0, sfr_pkg::OFS_TORQUE_LIM, 0);
		chk(q, 32'hffff_0100, "lane write");
		wb(1'b0, sfr_pkg::OFS_GEAR_BASIC, 0);
		chk(q, 32'h0001_0001, "gear reg reset");
		wb(1'b1, 8'h3c, 32'hffff_ffff);
		wb(1'b0, 8'h3c, 0);
		chk(q, 0, "unmapped read");
		hold(0, 10'h3ff);
		chk(motor_power_o, 0, "unassigned servo");
		chk(fwd_run_allow_o, 1, "unassigned travel");
		wb(1'b1, sfr_pkg::OFS_TORQUE_LIM, 32'h0200_0100);
		wb(1'b1, sfr_pkg::OFS_GEAR_SECOND, 32'h0005_0007);
		wb(1'b1, sfr_pkg::OFS_ZCLAMP, 32'h0000_000a);
		for (int k = 0; k < 3; k++)
			wb(1'b1, sfr_pkg::OFS_PRESET0 + 8'(4 * k), 32'(spd[k]));
		foreach (rows[i]) begin
			wb(1'b1, sfr_pkg::OFS_CTRL, 32'(rows[i].mode));
			map_fn(rows[i].fn, rows[i].ch);
			hold(rows[i].fn, 10'h1 << (rows[i].ch - 1));
			chk(probe(rows[i].fn), rows[i].on, "fn on");
			hold(rows[i].fn, 10'h0);
			chk(probe(rows[i].fn), 0, "fn off");
			map_fn(rows[i].fn, 0);
		end
		for (int m = 0; m < 8; m++) begin
			wb(1'b1, sfr_pkg::OFS_CTRL, 32'(m));
			repeat (3) @(posedge clk_i);
			chk(active_mode_o, mexp[m], "mode");
		end
		wb(1'b1, sfr_pkg::OFS_CTRL, 32'(sfr_pkg::MODE_PRESET));
		wb(1'b1, sfr_pkg::OFS_IN_MAP1, 32'h0000_0210);
		for (int k = 0; k < 4; k++) begin
			hold(0, 10'(k));
			chk(speed_cmd_o, spd[k], "preset select");
		end
		wb(1'b1, sfr_pkg::OFS_IN_MAP1, 0);
		q = 0;
		for (int c = 0; c < 6; c++)
			q |= 32'(1 + 3 * c) << (5 * c);
		wb(1'b1, sfr_pkg::OFS_OUT_MAP, q);
		for (int c = 0; c < 6; c++) begin
			@(posedge clk_i);
			out_func_i <= 16'h1 << (3 * c);
			repeat (2) @(posedge clk_i);
			chk(out_ch_o, 6'h1 << c, "output map");
		end
		wb(1'b1, sfr_pkg::OFS_OUT_MAP, 32'h0000_0011);
		out_func_i <= 16'hffff;
		repeat (2) @(posedge clk_i);
		chk(out_ch_o, 0, "output out of range");
		slow_q <= 1'b1;
		wb(1'b1, sfr_pkg::OFS_CTRL, 0);
		foreach (pfn[j]) begin
			map_fn(pfn[j], 10);
			hold(pfn[j], 10'h200);
			chk(n, 1, "one clear pulse");
			hold(pfn[j], 10'h0);
			map_fn(pfn[j], 0);
		end
		wb(1'b1, sfr_pkg::OFS_CTRL, 1);
		map_fn(15, 10);
		hold(15, 10'h200);
		chk(n, 0, "clear in speed mode");
		hold(15, 10'h0);
		map_fn(15, 0);
		map_fn(24, 10);
		hold(0, 10'h200);
		wb(1'b1, sfr_pkg::OFS_FUNC_STAT, 32'hffff_ffff);
		wb(1'b0, sfr_pkg::OFS_FUNC_STAT, 0);
		chk(q, 32'h0100_0000, "last function");
		wb(1'b0, sfr_pkg::OFS_PIN_STAT, 0);
		chk(q, 32'h0000_0200, "pin status");
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, sfr_pkg::OFS_TORQUE_LIM, 0);
		chk(q, 32'hffff_ffff, "limit after mid reset");
		finish_test();
	end
endmodule

`default_nettype wire
